// ---- hdl/gpwm_pkg.sv ----
// Package with constants and types for the GPIO pulse width modulator.
package gpwm_pkg;
  localparam int unsigned CHANNEL_COUNT = 4;
  localparam int unsigned PIN_COUNT = 16;
  localparam int unsigned PIN_W = 4;
  localparam int unsigned COUNT_W = 10;
  localparam logic [9:0] COUNT_SUM_MAX = 10'h3FF;
  localparam logic [9:0] COUNT_MIN = 10'h001;
  localparam longint unsigned CLK_HZ = 100000000;
  localparam longint unsigned TICK_HZ = 131072;
  localparam int unsigned TICK_DIV = 32'(CLK_HZ / TICK_HZ);
  localparam logic [9:0] TICK_DIV_LAST = 10'(TICK_DIV - 1);
  localparam logic [9:0] DIV_ZERO = 10'h000;
  // Pins that carry a modulator channel; index i gives the pin of channel i.
  localparam logic [3:0] CH_PIN [CHANNEL_COUNT] = '{4'h6, 4'hB, 4'hC, 4'hD};
  typedef enum logic [1:0] {
    GPWM_IDLE = 2'b00,
    GPWM_HIGH = 2'b01,
    GPWM_LOW  = 2'b11
  } gpwm_state_type;
endpackage

// ---- hdl/gpwm_chan_if.sv ----
// Interface carrying one channel's control and output between top and channel.
`timescale 1ns/1ns
interface gpwm_chan_if;
  logic start;
  logic stop;
  logic [9:0] high_count;
  logic [9:0] low_count;
  logic enable;
  logic level;
  logic running;
  modport ctrl (output start, output stop, output high_count, output low_count, output enable,
                input level, input running);
  modport chan (input start, input stop, input high_count, input low_count, input enable,
                output level, output running);
endinterface

// ---- hdl/gpwm_channel.sv ----
// One modulator channel: high for the on count, low for the off count, repeat.
`timescale 1ns/1ns
module gpwm_channel (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic tick_in,
  gpwm_chan_if.chan ch
);
  gpwm_pkg::gpwm_state_type state_q, state_d;
  logic [9:0] cnt_q, cnt_d;
  logic [9:0] high_q, high_d;
  logic [9:0] low_q, low_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    high_d = high_q;
    low_d = low_q;
    case (state_q)
      gpwm_pkg::GPWM_IDLE: begin
      end
      gpwm_pkg::GPWM_HIGH: begin
        if (tick_in) begin // [R1]
          if (cnt_q >= high_q) begin // [R2]
            state_d = gpwm_pkg::GPWM_LOW;
            cnt_d = gpwm_pkg::COUNT_MIN;
          end else begin
            cnt_d = cnt_q + gpwm_pkg::COUNT_MIN;
          end
        end
      end
      gpwm_pkg::GPWM_LOW: begin
        if (tick_in) begin
          if (cnt_q >= low_q) begin // [R2]
            state_d = gpwm_pkg::GPWM_HIGH;
            cnt_d = gpwm_pkg::COUNT_MIN;
          end else begin
            cnt_d = cnt_q + gpwm_pkg::COUNT_MIN;
          end
        end
      end
      default: state_d = gpwm_pkg::GPWM_IDLE;
    endcase
    if (ch.start) begin // [R5]
      high_d = ch.high_count;
      low_d = ch.low_count;
      cnt_d = gpwm_pkg::COUNT_MIN;
      state_d = gpwm_pkg::GPWM_HIGH;
    end
    if (ch.stop || !ch.enable) begin // [R5] [R6]
      state_d = gpwm_pkg::GPWM_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= gpwm_pkg::GPWM_IDLE;
      cnt_q <= gpwm_pkg::DIV_ZERO;
      high_q <= gpwm_pkg::COUNT_MIN;
      low_q <= gpwm_pkg::COUNT_MIN;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      high_q <= high_d;
      low_q <= low_d;
    end
  end

  assign ch.level = (state_q == gpwm_pkg::GPWM_HIGH);
  assign ch.running = (state_q != gpwm_pkg::GPWM_IDLE);
endmodule

// ---- hdl/gpwm_top.sv ----
// Top of the GPIO pulse width modulator: tick divider, command check, channels.
// Operation
// R1 - Counters advance on a 131072 Hz tick; durations count in ticks.
// R2 - Output high for on count ticks, then low for off count, repeating.
// R3 - On count plus off count never exceeds 1023.
// R4 - Full 100% duty is impossible; software uses plain I/O instead.
// R5 - A command loads off and on counts and runs, or stops the pin.
// R6 - Software assigns the pin to PWM before commanding it.
// R7 - Software derives counts from 131072, duty fraction and frequency.
// R8 - PWM function accepted only on pins with a modulator channel.
// R9 - Each count is at least one tick; shortest period two ticks.
`timescale 1ns/1ns
module gpwm_top (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic assign_valid_in,
  input wire logic [3:0] assign_pin_in,
  input wire logic assign_pwm_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_pin_in,
  input wire logic cmd_stop_in,
  input wire logic [9:0] cmd_low_count_in,
  input wire logic [9:0] cmd_high_count_in,
  output logic cmd_done_out,
  output logic cmd_fail_out,
  output logic assign_done_out,
  output logic assign_fail_out,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe_out,
  output logic [3:0] running_out
);
  localparam int unsigned NCH = gpwm_pkg::CHANNEL_COUNT;

  //////////////////////////////////////////////////////////////////////////////
  // Tick divider. It runs free from reset and is never restarted by a command,
  // so all channels count on one tick grid; the price is that the first high
  // phase after a start may fall up to one tick short of the programmed count.
  logic [9:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = (div_q == gpwm_pkg::TICK_DIV_LAST); // [R1]
    div_d = tick_d ? gpwm_pkg::DIV_ZERO : div_q + 10'h001;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      div_q <= gpwm_pkg::DIV_ZERO;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin decode. A pin number matches at most one channel, so these vectors are
  // one-hot or zero; pins without a channel never match.
  logic [NCH-1:0] asg_sel;
  logic [NCH-1:0] cmd_sel;

  for (genvar s = 0; s < NCH; s++) begin : g_sel
    assign asg_sel[s] = (assign_pin_in == gpwm_pkg::CH_PIN[s]); // [R8]
    assign cmd_sel[s] = (cmd_pin_in == gpwm_pkg::CH_PIN[s]);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin function ownership. Releasing the function also stops the channel, so a
  // pin never keeps driving after software has taken the function away.
  logic [NCH-1:0] fn_q, fn_d;
  logic asg_done_q, asg_done_d;
  logic asg_fail_q, asg_fail_d;

  always_comb begin
    fn_d = fn_q;
    if (assign_valid_in) begin
      for (int i = 0; i < NCH; i++) begin
        if (asg_sel[i]) begin
          fn_d[i] = assign_pwm_in;
        end
      end
    end
    asg_done_d = assign_valid_in && (asg_sel != '0);
    asg_fail_d = assign_valid_in && (asg_sel == '0); // [R8]
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fn_q <= '0;
      asg_done_q <= 1'b0;
      asg_fail_q <= 1'b0;
    end else begin
      fn_q <= fn_d;
      asg_done_q <= asg_done_d;
      asg_fail_q <= asg_fail_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command checking. A command sees the pin function as it stood before this
  // cycle, so an assign and a command in the same cycle do not interact.
  logic [NCH-1:0] start_q, start_d;
  logic [NCH-1:0] stop_q, stop_d;
  logic [9:0] hi_q, hi_d;
  logic [9:0] lo_q, lo_d;
  logic cmd_done_q, cmd_done_d;
  logic cmd_fail_q, cmd_fail_d;
  logic [10:0] sum;
  logic sum_ok;
  logic high_ok;
  logic low_ok;
  logic [NCH-1:0] cmd_own;

  assign sum = {1'b0, cmd_high_count_in} + {1'b0, cmd_low_count_in};
  assign sum_ok = (sum <= {1'b0, gpwm_pkg::COUNT_SUM_MAX}); // [R3]
  assign high_ok = (cmd_high_count_in >= gpwm_pkg::COUNT_MIN); // [R9]
  // A zero off count would mean a steady high, which the modulator must not make.
  assign low_ok = (cmd_low_count_in >= gpwm_pkg::COUNT_MIN); // [R9] [R4]
  assign cmd_own = cmd_sel & fn_q; // [R6]

  always_comb begin
    start_d = '0;
    stop_d = '0;
    hi_d = hi_q;
    lo_d = lo_q;
    cmd_done_d = 1'b0;
    cmd_fail_d = 1'b0;
    if (cmd_valid_in) begin
      if (cmd_own == '0) begin
        cmd_fail_d = 1'b1;
      end else if (cmd_stop_in) begin
        stop_d = cmd_own; // [R5]
        cmd_done_d = 1'b1;
      end else if (sum_ok && high_ok && low_ok) begin
        // Counts are latched only for an accepted start; a stop leaves them alone.
        start_d = cmd_own; // [R5]
        hi_d = cmd_high_count_in;
        lo_d = cmd_low_count_in;
        cmd_done_d = 1'b1;
      end else begin
        cmd_fail_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      start_q <= '0;
      stop_q <= '0;
      hi_q <= gpwm_pkg::COUNT_MIN;
      lo_q <= gpwm_pkg::COUNT_MIN;
      cmd_done_q <= 1'b0;
      cmd_fail_q <= 1'b0;
    end else begin
      start_q <= start_d;
      stop_q <= stop_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      cmd_done_q <= cmd_done_d;
      cmd_fail_q <= cmd_fail_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin outputs. A pin is driven only while its channel runs and the pin still
  // holds the function; every other pin stays released. The running flags are
  // registered here too, so they trail the channel state by one clock.
  logic [15:0] pin_q, pin_d;
  logic [15:0] oe_q, oe_d;
  logic [3:0] run_q, run_d;
  logic [NCH-1:0] lvl;
  logic [NCH-1:0] run;

  always_comb begin
    pin_d = '0;
    oe_d = '0;
    for (int i = 0; i < NCH; i++) begin
      pin_d[gpwm_pkg::CH_PIN[i]] = lvl[i];
      oe_d[gpwm_pkg::CH_PIN[i]] = fn_q[i] && run[i]; // [R6]
    end
    run_d = run;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q <= '0;
      oe_q <= '0;
      run_q <= '0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
      run_q <= run_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channels share the latched counts; only the started channel loads them.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    gpwm_chan_if cif ();
    assign cif.start = start_q[g];
    assign cif.stop = stop_q[g];
    assign cif.high_count = hi_q;
    assign cif.low_count = lo_q;
    assign cif.enable = fn_q[g];
    assign lvl[g] = cif.level;
    assign run[g] = cif.running;
    gpwm_channel u_ch (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .tick_in(tick_q),
      .ch(cif)
    );
  end

  assign cmd_done_out = cmd_done_q;
  assign cmd_fail_out = cmd_fail_q;
  assign assign_done_out = asg_done_q;
  assign assign_fail_out = asg_fail_q;
  assign pin_out = pin_q;
  assign pin_oe_out = oe_q;
  assign running_out = run_q;
endmodule

// ---- bench/gpwm_top_asserts.sv ----
// Checker of answers and refusals at the modulator top ports.
`timescale 1ns/1ns
module gpwm_top_asserts (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic assign_valid_in,
  input wire logic [3:0] assign_pin_in,
  input wire logic assign_pwm_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_pin_in,
  input wire logic cmd_stop_in,
  input wire logic [9:0] cmd_low_count_in,
  input wire logic [9:0] cmd_high_count_in,
  input wire logic cmd_done_out,
  input wire logic cmd_fail_out,
  input wire logic assign_done_out,
  input wire logic assign_fail_out,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_out,
  input wire logic [3:0] running_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  localparam int HIGH_MAX = 780549;
  logic [15:0] mask;
  logic [10:0] sum;
  logic [19:0] high_q;
  assign mask = 16'h3840;
  assign sum = {1'b0, cmd_low_count_in} + {1'b0, cmd_high_count_in};
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      high_q <= 20'h00000;
    end else if (!pin_out[13]) begin
      high_q <= 20'h00000;
    end else begin
      high_q <= high_q + 20'h00001;
    end
  end
  chk_cmd_answer: assert property (cmd_valid_in |=> cmd_done_out != cmd_fail_out) else $error("no answer");
  chk_cmd_quiet: assert property (!cmd_valid_in |=> !cmd_done_out && !cmd_fail_out) else $error("stray answer");
  chk_assign_answer: assert property (assign_valid_in |=> assign_done_out != assign_fail_out) else $error("no reply");
  chk_assign_nochan: assert property (assign_valid_in && assign_pwm_in && !mask[assign_pin_in] |=> assign_fail_out)
    else $error("bad pin taken");
  chk_zero_refused: assert property (cmd_valid_in && !cmd_stop_in && (cmd_low_count_in == 10'h000 ||
    cmd_high_count_in == 10'h000) |=> cmd_fail_out) else $error("zero taken");
  chk_sum_refused: assert property (cmd_valid_in && !cmd_stop_in && sum > 11'h3FF |=> cmd_fail_out)
    else $error("sum taken");
  chk_oe_chan_only: assert property ((pin_oe_out & ~mask) == 16'h0000) else $error("bad pin driven");
  chk_not_stuck: assert property (high_q <= HIGH_MAX) else $error("stuck high");
  cover property (cmd_fail_out);
  cover property (assign_fail_out);
  cover property ($rose(pin_out[13]));
endmodule
bind gpwm_top gpwm_top_asserts u_chk (.*);

// ---- bench/gpwm_load.sv ----
// Load on one modulator pin that measures its high and low run lengths.
`timescale 1ns/1ns
module gpwm_load (
  input wire logic clk_sys_in,
  input wire logic drive_in,
  input wire logic oe_in,
  output int high_len_out,
  output int low_len_out
);
  logic level;
  logic last_q = 1'b0;
  int run = 0;
  // An undriven pin reads low, as the load pulls it down.
  assign level = oe_in & drive_in;
  always @(posedge clk_sys_in) begin
    if (level != last_q && oe_in && last_q) high_len_out <= run;
    if (level != last_q && oe_in && !last_q) low_len_out <= run;
    run <= (level != last_q) ? 1 : run + 1;
    last_q <= level;
  end
endmodule

// ---- bench/test_gpwm_top.sv ----
// Self-checking bench of the modulator top with a load on pin 13.
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module test_gpwm_top;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic assign_valid_in = 1'b0;
  logic [3:0] assign_pin_in = 4'h0;
  logic assign_pwm_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [3:0] cmd_pin_in = 4'h0;
  logic cmd_stop_in = 1'b0;
  logic [9:0] cmd_low_count_in = 10'h000;
  logic [9:0] cmd_high_count_in = 10'h000;
  logic cmd_done_out, cmd_fail_out, assign_done_out, assign_fail_out;
  logic [15:0] pin_out, pin_oe_out;
  logic [3:0] running_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int high_len, low_len;
  gpwm_top u_dut (.*);
  gpwm_load u_load (.clk_sys_in(clk_sys_in), .drive_in(pin_out[13]), .oe_in(pin_oe_out[13]),
    .high_len_out(high_len), .low_len_out(low_len));
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  task automatic put_assign(input logic [3:0] pin, input logic pwm, input logic ok);
    assign_valid_in <= 1'b1;
    assign_pin_in <= pin;
    assign_pwm_in <= pwm;
    @(posedge clk_sys_in);
    assign_valid_in <= 1'b0;
    #1 `CHK({assign_done_out, assign_fail_out}, {ok, ~ok})
    @(posedge clk_sys_in);
  endtask
  task automatic put_cmd(input logic [3:0] pin, input logic stop, input logic [9:0] lo, hi, input logic ok);
    cmd_valid_in <= 1'b1;
    cmd_pin_in <= pin;
    cmd_stop_in <= stop;
    cmd_low_count_in <= lo;
    cmd_high_count_in <= hi;
    @(posedge clk_sys_in);
    cmd_valid_in <= 1'b0;
    #1 `CHK({cmd_done_out, cmd_fail_out}, {ok, ~ok})
    @(posedge clk_sys_in);
  endtask
  task automatic t_refuse();
    put_assign(4'h5, 1'b1, 1'b0);
    put_assign(4'hD, 1'b1, 1'b1);
    put_assign(4'h6, 1'b1, 1'b1);
    put_cmd(4'hC, 1'b0, 10'h003, 10'h002, 1'b0);
    put_cmd(4'hD, 1'b0, 10'h000, 10'h002, 1'b0);
    put_cmd(4'hD, 1'b0, 10'h003, 10'h000, 1'b0);
    put_cmd(4'h6, 1'b0, 10'h3FF, 10'h001, 1'b0);
    put_cmd(4'h6, 1'b0, 10'h3FE, 10'h001, 1'b1);
    put_cmd(4'h6, 1'b1, 10'h000, 10'h000, 1'b1);
  endtask
  // Counts follow the software formula for 16384 Hz at one quarter duty.
  localparam longint unsigned WAVE_HZ = 16384;
  localparam logic [9:0] WAVE_HI = 10'(gpwm_pkg::TICK_HZ / 4 / WAVE_HZ);
  localparam logic [9:0] WAVE_LO = 10'(gpwm_pkg::TICK_HZ * 3 / 4 / WAVE_HZ);
  task automatic t_wave();
    put_cmd(4'hD, 1'b0, WAVE_LO, WAVE_HI, 1'b1);
    repeat (20 * gpwm_pkg::TICK_DIV) @(posedge clk_sys_in);
    #1 `CHK(running_out, 4'h8)
    `CHK(high_len, int'(WAVE_HI) * int'(gpwm_pkg::TICK_DIV))
    `CHK(low_len, int'(WAVE_LO) * int'(gpwm_pkg::TICK_DIV))
    @(posedge clk_sys_in);
    put_cmd(4'hD, 1'b1, 10'h000, 10'h000, 1'b1);
    @(posedge clk_sys_in);
    #1 `CHK(pin_oe_out, 16'h0000)
  endtask
  task automatic t_release();
    @(posedge clk_sys_in);
    put_cmd(4'hD, 1'b0, 10'h001, 10'h001, 1'b1);
    put_assign(4'hD, 1'b0, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    `CHK(running_out, 4'h0)
    put_cmd(4'hD, 1'b0, 10'h003, 10'h002, 1'b0);
  endtask
  task automatic tally_and_finish();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_refuse();
    t_wave();
    t_release();
    tally_and_finish();
  end
  // The ceiling is about two and a half times the longest expected run.
  always @(posedge clk_sys_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
endmodule
